// ==== common/codec_iface_defines.vh ====
// Purpose: Constants for the codec serial interface buffer block
// Assumes: 16-bit register words, 4-bit register index
// Notes: Register index = address on the plain register port
`ifndef CODEC_IFACE_DEFINES_VH
`define CODEC_IFACE_DEFINES_VH

// Register indices
`define REG_CTRL 4'h0
`define REG_TX_SLOT_EN 4'h1
`define REG_RX_SLOT_EN 4'h2
`define REG_STATUS 4'h3
`define REG_RX_WORD0 4'h4
`define REG_TX_WORD0 4'h8
`define REG_WORD_BANK_W 2

// Control register fields
`define CTRL_DEPTH_LO 0
`define CTRL_DEPTH_HI 1
`define CTRL_IDLE_DRIVE 2
`define CTRL_LOOPBACK 3
`define CTRL_STARVE_FILL 4
`define CTRL_SLOTS_LO 8
`define CTRL_SLOTS_HI 11

// Status register fields
`define STAT_TX_FREE 0
`define STAT_TX_STARVED 1
`define STAT_RX_WAITING 2
`define STAT_RX_OVERRUN 3
`define STAT_SLOT_LO 8
`define STAT_SLOT_HI 11

// Reset values
`define CTRL_RESET 16'h0000
`define SLOT_EN_RESET 16'h0000
`define WORD_RESET 16'h0000

// Serial word timing
`define LAST_BIT 4'hF

`endif

// ==== core/codec_serial_iface.v ====
// Purpose: Buffer control, status and data pin logic of a codec serial port
// Assumes: Frame sync slave, 16-bit slots, bit clock sampled on CLK_I
// Notes: Output changes after bit clock fall, input sampled at rise
`timescale 1ns/1ps
`default_nettype none
`include "codec_iface_defines.vh"

module codec_serial_iface (
    input wire CLK_I,
    input wire RESETN_I,
    input wire [3:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [15:0] RDATA_O,
    input wire BIT_CLK_PIN_I,
    input wire FRAME_SYNC_PIN_I,
    input wire SERIAL_IN_PIN_I,
    output wire SERIAL_OUT_PIN_O,
    output wire SERIAL_OUT_PIN_OE_N_O,
    output wire XFER_IRQ_O
);
    // Frame states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;
    // Software registers and their shadows
    reg [15:0] ctrl_reg; // Mode and depth control
    reg [15:0] tx_slot_enable_reg; // Per-slot transmit enable
    reg [15:0] rx_slot_enable_reg; // Per-slot receive enable
    reg [15:0] tx_word_regs [0:3]; // CPU transmit words
    reg [15:0] rx_word_regs [0:3]; // CPU receive words
    reg [15:0] tx_shadow [0:3]; // Words being sent
    reg [15:0] rx_shadow [0:3]; // Words being gathered

    // Per-word bookkeeping
    reg [3:0] tx_written_reg; // Refilled since last swap
    reg [3:0] tx_starve_loc_reg; // Underflowed words
    reg [3:0] rx_unread_reg; // Filled, not yet read
    reg [3:0] rx_overrun_loc_reg; // Overrun words
    reg tx_free_reg; // Tx buffers may be written
    reg [3:0] tx_zero_fill_reg; // Starved at last swap, kept for sending
    // Serial engine state
    reg [1:0] state_reg;
    reg [1:0] buffer_word_pointer_reg; // Word pointer into shadows
    reg [3:0] slot_reg; // Frame slot counter
    reg [3:0] bit_cnt_reg; // Bit within slot
    reg [15:0] tx_shift_reg; // Outgoing shift register
    reg [15:0] rx_shift_reg; // Incoming shift register
    reg out_bit_reg; // Level on the data pin
    reg oe_n_reg; // Pin released when high
    reg irq_reg; // Swap pulse
    // Pin synchronisers
    reg sck_s1_reg;
    reg sck_s2_reg;
    reg sck_s3_reg;
    reg fs_s1_reg;
    reg fs_s2_reg;
    reg din_s1_reg;
    reg din_s2_reg;
    // Control fields
    wire [1:0] buffer_depth_sel = ctrl_reg[`CTRL_DEPTH_HI:`CTRL_DEPTH_LO];
    wire idle_drive_select = ctrl_reg[`CTRL_IDLE_DRIVE];
    wire internal_loopback = ctrl_reg[`CTRL_LOOPBACK];
    wire starve_fill_select = ctrl_reg[`CTRL_STARVE_FILL];
    wire [3:0] last_slot = ctrl_reg[`CTRL_SLOTS_HI:`CTRL_SLOTS_LO];

    // Bit clock edges from synchronised copies
    wire sck_rise = sck_s2_reg & ~sck_s3_reg;
    wire sck_fall = ~sck_s2_reg & sck_s3_reg;
    wire running = state_reg[1];
    // Slot enables of the current slot
    wire tx_slot_enable_bit = tx_slot_enable_reg[slot_reg];
    wire rx_slot_enable_bit = rx_slot_enable_reg[slot_reg];

    // Words in use for the chosen depth
    reg [3:0] in_use;
    always @* begin
        case (buffer_depth_sel)
            2'd0: in_use = 4'b0001;
            2'd1: in_use = 4'b0011;
            2'd2: in_use = 4'b0111;
            default: in_use = 4'b1111;
        endcase
    end

    // Input path, loopback ignores the pin
    wire rx_in = internal_loopback ? out_bit_reg : din_s2_reg;

    // Last bit of an active slot ends here
    wire slot_end = running && sck_rise && (bit_cnt_reg == `LAST_BIT);
    wire slot_used = tx_slot_enable_bit | rx_slot_enable_bit;
    wire step = slot_end & slot_used;
    wire swap = step && (buffer_word_pointer_reg == buffer_depth_sel);
    wire [15:0] rx_word_in = {rx_shift_reg[14:0], rx_in};
    wire [3:0] rx_fill_hit = rx_slot_enable_bit ? (4'b0001 << buffer_word_pointer_reg) : 4'b0000;
    // Word loaded at slot start, starved words filled
    wire [15:0] shadow_now = tx_shadow[buffer_word_pointer_reg];
    wire starved_now = tx_zero_fill_reg[buffer_word_pointer_reg];
    wire [15:0] load_word = (starved_now & ~starve_fill_select) ?
        `WORD_RESET : shadow_now;

    // Register port decode
    wire is_rx_word = (ADDR_I >> `REG_WORD_BANK_W) == (`REG_RX_WORD0 >> `REG_WORD_BANK_W);
    wire is_tx_word = (ADDR_I >> `REG_WORD_BANK_W) == (`REG_TX_WORD0 >> `REG_WORD_BANK_W);
    wire [1:0] word_idx = ADDR_I[1:0];
    wire [3:0] tx_wr_hit = (WR_I && is_tx_word) ? (4'b0001 << word_idx) : 4'b0000;
    wire [3:0] rx_rd_hit = (RD_I && is_rx_word) ? (4'b0001 << word_idx) : 4'b0000;
    // Status word
    wire tx_starved_flag = |(tx_starve_loc_reg & in_use);
    wire rx_data_waiting_flag = |(rx_unread_reg & in_use);
    wire rx_overrun_flag = |(rx_overrun_loc_reg & in_use);
    wire [15:0] serial_iface_status = {4'h0, slot_reg, 4'h0,
        rx_overrun_flag, rx_data_waiting_flag, tx_starved_flag, tx_free_reg};

    assign SERIAL_OUT_PIN_O = out_bit_reg;
    assign SERIAL_OUT_PIN_OE_N_O = oe_n_reg;
    assign XFER_IRQ_O = irq_reg;

    // Two-flop synchronisers for pin inputs
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            fs_s1_reg <= 1'b0;
            fs_s2_reg <= 1'b0;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end else begin
            sck_s1_reg <= BIT_CLK_PIN_I;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            fs_s1_reg <= FRAME_SYNC_PIN_I;
            fs_s2_reg <= fs_s1_reg;
            din_s1_reg <= SERIAL_IN_PIN_I;
            din_s2_reg <= din_s1_reg;
        end
    end

    // Control registers and CPU transmit words
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_reg <= `CTRL_RESET;
            tx_slot_enable_reg <= `SLOT_EN_RESET;
            rx_slot_enable_reg <= `SLOT_EN_RESET;
            tx_word_regs[0] <= `WORD_RESET;
            tx_word_regs[1] <= `WORD_RESET;
            tx_word_regs[2] <= `WORD_RESET;
            tx_word_regs[3] <= `WORD_RESET;
        end else if (WR_I) begin
            // Writes to read-only or unmapped words are dropped
            if (ADDR_I == `REG_CTRL) begin
                ctrl_reg <= WDATA_I;
            end else if (ADDR_I == `REG_TX_SLOT_EN) begin
                tx_slot_enable_reg <= WDATA_I;
            end else if (ADDR_I == `REG_RX_SLOT_EN) begin
                rx_slot_enable_reg <= WDATA_I;
            end else if (is_tx_word) begin
                tx_word_regs[word_idx] <= WDATA_I;
            end
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RDATA_O <= `WORD_RESET;
        end else if (RD_I) begin
            if (ADDR_I == `REG_CTRL) begin
                RDATA_O <= ctrl_reg;
            end else if (ADDR_I == `REG_TX_SLOT_EN) begin
                RDATA_O <= tx_slot_enable_reg;
            end else if (ADDR_I == `REG_RX_SLOT_EN) begin
                RDATA_O <= rx_slot_enable_reg;
            end else if (ADDR_I == `REG_STATUS) begin
                RDATA_O <= serial_iface_status;
            end else if (is_rx_word) begin
                RDATA_O <= rx_word_regs[word_idx];
            end else if (is_tx_word) begin
                RDATA_O <= tx_word_regs[word_idx];
            end else begin
                // Unmapped index reads zero
                RDATA_O <= `WORD_RESET;
            end
        end else begin
            RDATA_O <= `WORD_RESET;
        end
    end

    // Transmit status; hardware set wins over clear
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_free_reg <= 1'b0;
            tx_written_reg <= 4'b0000;
            tx_starve_loc_reg <= 4'b0000;
            tx_zero_fill_reg <= 4'b0000;
        end else begin
            if (swap) begin
                tx_free_reg <= 1'b1;
                tx_zero_fill_reg <= in_use & ~tx_written_reg;
                tx_starve_loc_reg <= (tx_starve_loc_reg & ~tx_wr_hit) |
                    (in_use & ~tx_written_reg);
                tx_written_reg <= (tx_written_reg & ~in_use) | tx_wr_hit;
            end else begin
                if (|tx_wr_hit) begin
                    tx_free_reg <= 1'b0;
                end
                tx_starve_loc_reg <= tx_starve_loc_reg & ~tx_wr_hit;
                tx_written_reg <= tx_written_reg | tx_wr_hit;
            end
        end
    end

    // Receive status and receive words
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_unread_reg <= 4'b0000;
            rx_overrun_loc_reg <= 4'b0000;
            rx_word_regs[0] <= `WORD_RESET;
            rx_word_regs[1] <= `WORD_RESET;
            rx_word_regs[2] <= `WORD_RESET;
            rx_word_regs[3] <= `WORD_RESET;
        end else if (swap) begin
            // Used words overwritten even when unread; last word bypasses shadow
            if (in_use[0]) rx_word_regs[0] <= rx_fill_hit[0] ? rx_word_in : rx_shadow[0];
            if (in_use[1]) rx_word_regs[1] <= rx_fill_hit[1] ? rx_word_in : rx_shadow[1];
            if (in_use[2]) rx_word_regs[2] <= rx_fill_hit[2] ? rx_word_in : rx_shadow[2];
            if (in_use[3]) rx_word_regs[3] <= rx_fill_hit[3] ? rx_word_in : rx_shadow[3];
            rx_overrun_loc_reg <= (rx_overrun_loc_reg & ~rx_rd_hit) |
                (in_use & rx_unread_reg);
            rx_unread_reg <= (rx_unread_reg & ~rx_rd_hit) | in_use;
        end else begin
            rx_overrun_loc_reg <= rx_overrun_loc_reg & ~rx_rd_hit;
            rx_unread_reg <= rx_unread_reg & ~rx_rd_hit;
        end
    end

    // Transmit shadows take the CPU words at swap
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_shadow[0] <= `WORD_RESET;
            tx_shadow[1] <= `WORD_RESET;
            tx_shadow[2] <= `WORD_RESET;
            tx_shadow[3] <= `WORD_RESET;
        end else if (swap) begin
            tx_shadow[0] <= tx_word_regs[0];
            tx_shadow[1] <= tx_word_regs[1];
            tx_shadow[2] <= tx_word_regs[2];
            tx_shadow[3] <= tx_word_regs[3];
        end
    end

    // Receive shadows fill only in receive slots
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rx_shadow[0] <= `WORD_RESET;
            rx_shadow[1] <= `WORD_RESET;
            rx_shadow[2] <= `WORD_RESET;
            rx_shadow[3] <= `WORD_RESET;
        end else if (slot_end && rx_slot_enable_bit) begin
            rx_shadow[buffer_word_pointer_reg] <= rx_word_in;
        end
    end

    // Frame state, slot and pointer stepping
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_reg <= ST_IDLE;
            buffer_word_pointer_reg <= 2'd0;
            slot_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= swap;
            if (swap) begin
                buffer_word_pointer_reg <= 2'd0;
            end else if (step) begin
                buffer_word_pointer_reg <= buffer_word_pointer_reg + 2'd1;
            end
            case (state_reg)
                ST_IDLE: begin
                    // Wait for frame sync at a bit clock rise
                    if (sck_rise && fs_s2_reg) begin
                        state_reg <= ST_RUN;
                        slot_reg <= 4'h0;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                ST_RUN: begin
                    if (sck_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (slot_end) begin
                        if (slot_reg == last_slot) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            slot_reg <= slot_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Shift registers and data pin drive
    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tx_shift_reg <= `WORD_RESET;
            rx_shift_reg <= `WORD_RESET;
            out_bit_reg <= 1'b0;
            oe_n_reg <= 1'b0;
        end else begin
            if (running && sck_rise) begin
                rx_shift_reg <= rx_word_in;
            end
            if (running && sck_fall) begin
                if (!tx_slot_enable_bit) begin
                    // Unused slot: low, or released
                    out_bit_reg <= 1'b0;
                    oe_n_reg <= idle_drive_select;
                end else if (bit_cnt_reg == 4'h0) begin
                    // Slot start loads the current shadow word
                    out_bit_reg <= load_word[15];
                    tx_shift_reg <= {load_word[14:0], 1'b0};
                    oe_n_reg <= 1'b0;
                end else begin
                    out_bit_reg <= tx_shift_reg[15];
                    tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
                    oe_n_reg <= 1'b0;
                end
            end else if (!running && sck_fall) begin
                // Between frames the pin counts as unused
                out_bit_reg <= 1'b0;
                oe_n_reg <= idle_drive_select;
            end
        end
    end

endmodule // codec_serial_iface
`default_nettype wire

// ==== tb/codec_serial_iface_sva.sv ====
// Purpose: Port-level assertions for the codec serial interface block
// Assumes: Bit clock edges reach the block logic within a few clock cycles
// Notes: Helper logic tracks bit clock edge age and control writes
`timescale 1ns/1ps
`default_nettype none
module codec_serial_iface_sva (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic BIT_CLK_PIN_I,
    input wire logic FRAME_SYNC_PIN_I,
    input wire logic SERIAL_IN_PIN_I,
    input wire logic SERIAL_OUT_PIN_O,
    input wire logic SERIAL_OUT_PIN_OE_N_O,
    input wire logic XFER_IRQ_O
);
    logic bck_reg; // Bit clock seen last cycle
    logic [3:0] rise_age_reg; // Cycles since a bit clock rise, saturating
    logic [3:0] fall_age_reg; // Cycles since a bit clock fall, saturating
    logic idle_reg; // Release select as last written
    logic [3:0] last_reg; // Last slot index as last written
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    // Edge ages and a copy of the release select and last slot fields
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            bck_reg <= 1'b0;
            rise_age_reg <= 4'hF;
            fall_age_reg <= 4'hF;
            idle_reg <= 1'b0;
            last_reg <= 4'h0;
        end else begin
            bck_reg <= BIT_CLK_PIN_I;
            rise_age_reg <= (BIT_CLK_PIN_I && !bck_reg) ? 4'h0
                : rise_age_reg + {3'b000, rise_age_reg != 4'hF};
            fall_age_reg <= (!BIT_CLK_PIN_I && bck_reg) ? 4'h0
                : fall_age_reg + {3'b000, fall_age_reg != 4'hF};
            // Control write updates the copies
            if (WR_I && ADDR_I == 4'h0) begin
                idle_reg <= WDATA_I[2];
                last_reg <= WDATA_I[11:8];
            end
        end
    end
    irq_gap_a: assert property (XFER_IRQ_O |=> !XFER_IRQ_O [*8])
        else $error("interrupt repeated too soon");
    irq_near_rise_a: assert property (XFER_IRQ_O |-> rise_age_reg <= 4'd8)
        else $error("interrupt not tied to a bit clock rise");
    out_after_edge_a: assert property ($changed(SERIAL_OUT_PIN_O)
        || $changed(SERIAL_OUT_PIN_OE_N_O) |-> fall_age_reg <= 4'd6 || rise_age_reg <= 4'd6)
        else $error("serial output moved away from a bit clock edge");
    release_needs_idle_a: assert property ($rose(SERIAL_OUT_PIN_OE_N_O) |-> idle_reg)
        else $error("line released while release select clear");
    status_zero_bits_a: assert property (RD_I && ADDR_I == 4'h3
        |=> RDATA_O[15:12] == 4'h0 && RDATA_O[7:4] == 4'h0)
        else $error("status spare bits not zero");
    slot_in_range_a: assert property (RD_I && ADDR_I == 4'h3
        |=> RDATA_O[11:8] <= last_reg)
        else $error("slot field beyond last slot");
    tx_free_clear_a: assert property (WR_I && ADDR_I[3:2] == 2'b10
        ##[1:2] RD_I && ADDR_I == 4'h3 |=> !RDATA_O[0])
        else $error("tx free flag still set after word write");
    reset_quiet_a: assert property ($rose(RESETN_I)
        |-> RDATA_O == 16'h0000 && !XFER_IRQ_O && !SERIAL_OUT_PIN_O)
        else $error("outputs not quiet after reset");
endmodule // codec_serial_iface_sva
bind codec_serial_iface codec_serial_iface_sva i_codec_serial_iface_sva (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .BIT_CLK_PIN_I(BIT_CLK_PIN_I),
    .FRAME_SYNC_PIN_I(FRAME_SYNC_PIN_I), .SERIAL_IN_PIN_I(SERIAL_IN_PIN_I),
    .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O), .SERIAL_OUT_PIN_OE_N_O(SERIAL_OUT_PIN_OE_N_O),
    .XFER_IRQ_O(XFER_IRQ_O));
`default_nettype wire

// ==== tb/codec_model.sv ====
// Purpose: Behavioural codec on the far side of the serial link
// Assumes: Codec makes bit clock and frame sync, 16-bit slots MSB first
// Notes: Bit clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module codec_model (
    output logic bck_o,
    output logic fsync_o,
    output logic sdin_o,
    input wire logic sdout_i,
    input wire logic sdout_oe_n_i
);
    logic [15:0] rx_word [0:15]; // Words the codec sends
    logic [15:0] tx_seen [0:15]; // Words seen on the out line
    logic [15:0] hiz_seen; // Slots where the out line was released
    int half_ns = 40; // Half bit period, raised for a slow codec
    // Idle levels
    initial begin
        bck_o = 1'b0;
        fsync_o = 1'b0;
        sdin_o = 1'b0;
    end
    // One frame: sync at the first rise, then slots of 16 bits
    task automatic run_frame(input int slots);
        fsync_o = 1'b1;
        #(half_ns);
        bck_o = 1'b1;
        #(half_ns);
        bck_o = 1'b0;
        fsync_o = 1'b0;
        for (int s = 0; s < slots; s++) begin
            hiz_seen[s] = 1'b0;
            for (int b = 15; b >= 0; b--) begin
                sdin_o = rx_word[s][b];
                #(half_ns);
                bck_o = 1'b1;
                // Released line reads as the inverse of the pin
                tx_seen[s][b] = sdout_i ^ sdout_oe_n_i;
                hiz_seen[s] = hiz_seen[s] | sdout_oe_n_i;
                #(half_ns);
                bck_o = 1'b0;
            end
        end
        sdin_o = ~sdin_o;
    endtask
endmodule // codec_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the codec serial interface block
// Assumes: Codec model drives bit clock, frame sync and serial input
// Notes: Read results are checked against a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic CLK_I, RESETN_I, WR_I, RD_I, rd_d;
    logic [3:0] ADDR_I;
    logic [15:0] WDATA_I;
    logic [15:0] r_word [0:1]; // Words the codec sent last frame
    logic [15:0] tw [0:7]; // Random transmit words
    logic [15:0] exp_q[$], mask_q[$]; // Pending read expectations
    wire [15:0] RDATA_O;
    wire bck, fsync, sdin, sdout, sdout_oe_n, irq;
    int bad_count, tests_run, irq_count, irq_exp;
    localparam logic [15:0] M = 16'h000F; // Status flag bits
    codec_serial_iface i_codec_serial_iface (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .BIT_CLK_PIN_I(bck), .FRAME_SYNC_PIN_I(fsync), .SERIAL_IN_PIN_I(sdin),
        .SERIAL_OUT_PIN_O(sdout), .SERIAL_OUT_PIN_OE_N_O(sdout_oe_n), .XFER_IRQ_O(irq));
    codec_model i_codec_model (.bck_o(bck), .fsync_o(fsync), .sdin_o(sdin),
        .sdout_i(sdout), .sdout_oe_n_i(sdout_oe_n));
    // Clock, 4 ns
    initial begin
        CLK_I = 1'b0;
        forever #2 CLK_I = ~CLK_I;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        exp_q.push_back(e);
        mask_q.push_back(m);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
    endtask
    // One codec frame of two slots with fresh random input words
    task automatic frame(input int irqs = 1);
        repeat (4) @(posedge CLK_I);
        #1; // Codec pins move off the clock edges
        for (int s = 0; s < 2; s++) begin
            r_word[s] = 16'($urandom);
            i_codec_model.rx_word[s] = r_word[s];
        end
        i_codec_model.run_frame(2);
        repeat (20) @(posedge CLK_I);
        irq_exp += irqs;
        check(16'(irq_count), 16'(irq_exp));
    endtask
    task automatic done(input string n);
        $display("Test %s finished", n);
    endtask
    // Result watcher: read data one cycle after the strobe, interrupt count
    always @(posedge CLK_I) begin
        if (rd_d)
            check(RDATA_O & mask_q.pop_front(), exp_q.pop_front());
        rd_d <= RD_I;
        if (irq === 1'b1)
            irq_count++;
    end
    // Hang guard
    initial begin
        repeat (50000) @(posedge CLK_I);
        bad_count++;
        summarize();
    end
    // Main sequence
    initial begin
        {RESETN_I, WR_I, RD_I, rd_d, ADDR_I, WDATA_I} = '0;
        void'($urandom(32'h15819991));
        for (int i = 0; i < 8; i++) tw[i] = 16'($urandom);
        repeat (2) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        for (int a = 0; a < 13; a++) rd(4'(a), 16'h0000);
        wr(4'h0, 16'h0101);
        wr(4'h1, 16'h0003);
        wr(4'h2, 16'h0003);
        wr(4'h3, 16'hFFFF);
        wr(4'h4, 16'hFFFF);
        wr(4'hC, 16'hFFFF);
        rd(4'h0, 16'h0101);
        rd(4'h1, 16'h0003);
        rd(4'h2, 16'h0003);
        rd(4'h3, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'hC, 16'h0000);
        done("registers");
        wr(4'h8, tw[0]);
        wr(4'h9, tw[1]);
        frame();
        check(i_codec_model.tx_seen[0], 16'h0000);
        check(i_codec_model.tx_seen[1], 16'h0000);
        rd(4'h3, 16'h0005, M);
        rd(4'h4, r_word[0]);
        rd(4'h5, r_word[1]);
        rd(4'h3, 16'h0001, M);
        frame();
        check(i_codec_model.tx_seen[0], tw[0]);
        check(i_codec_model.tx_seen[1], tw[1]);
        rd(4'h3, 16'h0007, M);
        done("swap");
        wr(4'h8, tw[2]);
        rd(4'h3, 16'h0006, M);
        wr(4'h9, tw[3]);
        rd(4'h3, 16'h0004, M);
        frame();
        check(i_codec_model.tx_seen[0], 16'h0000);
        check(i_codec_model.tx_seen[1], 16'h0000);
        rd(4'h3, 16'h000D, M);
        rd(4'h4, r_word[0]);
        rd(4'h3, 16'h000D, M);
        rd(4'h5, r_word[1]);
        rd(4'h3, 16'h0001, M);
        done("starve and overrun");
        wr(4'h0, 16'h0111);
        frame();
        frame();
        check(i_codec_model.tx_seen[0], tw[2]);
        check(i_codec_model.tx_seen[1], tw[3]);
        rd(4'h4, r_word[0]);
        rd(4'h5, r_word[1]);
        done("fill");
        wr(4'h0, 16'h0104);
        wr(4'h1, 16'h0001);
        wr(4'h2, 16'h0001);
        wr(4'h8, tw[4]);
        wr(4'h9, tw[5]);
        frame();
        check(i_codec_model.tx_seen[0], 16'h0000);
        check({15'h0000, i_codec_model.hiz_seen[1]}, 16'h0001);
        check({15'h0000, i_codec_model.hiz_seen[0]}, 16'h0000);
        rd(4'h3, 16'h0005, M);
        rd(4'h4, r_word[0]);
        wr(4'h0, 16'h0100);
        frame();
        check(i_codec_model.tx_seen[0], tw[4]);
        check(i_codec_model.tx_seen[1], 16'h0000);
        check({15'h0000, i_codec_model.hiz_seen[1]}, 16'h0000);
        done("idle drive");
        i_codec_model.half_ns = 100;
        wr(4'h0, 16'h0109);
        wr(4'h1, 16'h0003);
        wr(4'h2, 16'h0003);
        wr(4'h8, tw[6]);
        wr(4'h9, tw[7]);
        frame();
        frame();
        check(i_codec_model.tx_seen[0], tw[6]);
        check(i_codec_model.tx_seen[1], tw[7]);
        rd(4'h4, tw[6]);
        rd(4'h5, tw[7]);
        done("loopback");
        wr(4'h0, 16'h0103);
        frame(0);
        frame();
        rd(4'h6, r_word[0]);
        rd(4'h7, r_word[1]);
        done("four words");
        repeat (3) @(posedge CLK_I);
        RESETN_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        rd(4'h0, 16'h0000);
        rd(4'h3, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'h8, 16'h0000);
        done("second reset");
        repeat (4) @(posedge CLK_I);
        summarize();
    end
endmodule // testbench
`default_nettype wire
